// ===== serial_channel_control.sv
// Per-channel control: command decode, service requests, format and
// flow options. Assumes a classic Wishbone master on the register side
// and a serial datapath that reports FIFO and receive events.
// Function
// - Channel-control command is bits 7..5 zero and bit 4 one.
// - Bits 3..0 enable/disable transmitter and receiver, combined freely.
// - Enable or disable commands leave configuration registers alone.
// - Any enable/disable command resumes flow-halted transmit, clears flag; with flow bit 6 set, a stop character in the same cycle sets it.
// - Enable register at 06; bit 7 posts modem-change requests.
// - Requests show in status register and active-low pin, gated singly; parity-error exceptions have no enable.
// - Bit 4: receive request on threshold or timeout with data.
// - Bit 2 asks on transmit FIFO empty, bit 1 on shift empty.
// - FIFO-empty request leaves two characters still to send.
// - Bit 0: drained FIFO plus timeout gives data-less exception, flag 7.
// - Timeout request vector reports a receive exception type.
// - Format bit 7 at 08 selects odd (1) or even (0) parity.
// - Parity mode: none, forced, normal, unused; both directions.
// - Format bit 4 set ignores incoming parity errors.
// - Stop field: one, one and a half, two bits, unused.
// - Length field: five to eight bits, shared by both directions.
// - Flow bit 7 at 09: any non-stop character resumes, else resume only.
// - Command register clears after execution; host waits for zero.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "scc_defs.svh"

module serial_channel_control #(
  parameter int TICK_CYCLES = `TMO_TICK_CYCLES
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Register bus
  input wire scc_pkg::wb_req_t wb_req_i,
  output scc_pkg::wb_rsp_t wb_rsp_o,
  // Datapath status
  input wire logic tx_fifo_empty_i,
  input wire logic tx_shift_empty_i,
  input wire logic rx_fifo_nonempty_i,
  input wire logic rx_thresh_i,
  input wire logic modem_change_i,
  // Received character
  input wire logic rx_char_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_par_bit_i,
  input wire logic rx_xoff_match_i,
  input wire logic rx_xon_match_i,
  // Channel control
  output logic tx_enable_o,
  output logic rx_enable_o,
  output logic tx_flow_off_flag_o,
  output logic service_request_n_o,
  output scc_pkg::frame_cfg_t frame_cfg_o
);
  import scc_pkg::*;

  function automatic logic is_ctrl(input logic [7:0] c);
    return (c[7:4] == `CMD_TYPE_CTRL);
  endfunction

  logic ack_q;
  logic [31:0] rdat_q;
  logic [7:0] channel_command_reg_q;
  logic [7:0] service_request_enable_q;
  logic [7:0] char_format_option_q;
  logic [7:0] flow_loop_option_q;
  logic [7:0] rx_timeout_period_q;
  logic [3:0] svc_status_q;
  logic no_new_data_timeout_en_flag_q;
  logic tx_en_q;
  logic rx_en_q;
  logic flow_off_q;
  logic req_n_q;
  cmd_state_t state_q;
  logic [15:0] tick_cnt_q;
  logic [7:0] tmo_cnt_q;
  logic armed_q;
  logic par_err;
  logic [5:0] idx;
  logic req;
  logic wr_go;
  logic ctrl_exec;
  logic expired;
  logic no_new_data_timeout_en_fire;
  logic [7:0] ccs;
  logic [2:0] vec;
  logic [7:0] rd_mux;

  assign idx = wb_req_i.adr[7:2];
  assign req = wb_req_i.cyc && wb_req_i.stb;
  // Writes land on the edge where the master sees ack
  assign wr_go = req && wb_req_i.we && ack_q && wb_req_i.sel[0];
  assign ctrl_exec = (state_q == CMD_EXEC) &&
    is_ctrl(channel_command_reg_q) &&
    (channel_command_reg_q[3:0] != 4'h0);

  assign wb_rsp_o.ack = ack_q;
  assign wb_rsp_o.dat = rdat_q;
  assign tx_enable_o = tx_en_q;
  assign rx_enable_o = rx_en_q;
  assign tx_flow_off_flag_o = flow_off_q;
  assign service_request_n_o = req_n_q;

  scc_char_framer u_framer (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .fmt_i(char_format_option_q),
    .rx_valid_i(rx_char_valid_i),
    .rx_char_i(rx_char_i),
    .rx_par_i(rx_par_bit_i),
    .cfg_o(frame_cfg_o),
    .rx_par_err_o(par_err)
  );

  assign ccs = {5'h00, flow_off_q, rx_en_q, tx_en_q};

  // Receive exception outranks data, transmit and modem requests
  always_comb begin
    vec = `VEC_NONE;
    if (svc_status_q[`SVS_EXC]) begin
      vec = `VEC_RX_EXC;
    end else if (svc_status_q[`SVS_RX]) begin
      vec = `VEC_RX_DATA;
    end else if (svc_status_q[`SVS_TX]) begin
      vec = `VEC_TX;
    end else if (svc_status_q[`SVS_MDM]) begin
      vec = `VEC_MODEM;
    end
  end

  always_comb begin
    case (idx)
      `IDX_CMD: rd_mux = channel_command_reg_q;
      `IDX_SRE: rd_mux = service_request_enable_q & `SRE_MASK;
      `IDX_FMT: rd_mux = char_format_option_q;
      `IDX_FLO: rd_mux = flow_loop_option_q;
      `IDX_CCS: rd_mux = ccs;
      `IDX_SVS: rd_mux = {4'h0, svc_status_q};
      `IDX_RDS: rd_mux = {no_new_data_timeout_en_flag_q, 7'h00};
      `IDX_RTP: rd_mux = rx_timeout_period_q;
      `IDX_VEC: rd_mux = {5'h00, vec};
      default: rd_mux = `RST_BYTE;
    endcase
  end

  // One wait state: ack rises the cycle after the request, then drops
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end else begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) begin
        rdat_q <= {24'h00_0000, rd_mux};
      end
    end
  end

  // Configuration registers; command execution never writes these
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      service_request_enable_q <= `RST_BYTE;
      char_format_option_q <= `RST_BYTE;
      flow_loop_option_q <= `RST_BYTE;
      rx_timeout_period_q <= `RST_BYTE;
    end else if (wr_go) begin
      case (idx)
        `IDX_SRE: service_request_enable_q <=
          wb_req_i.dat[7:0] & `SRE_MASK;
        `IDX_FMT: char_format_option_q <= wb_req_i.dat[7:0];
        `IDX_FLO: flow_loop_option_q <= wb_req_i.dat[7:0];
        `IDX_RTP: rx_timeout_period_q <= wb_req_i.dat[7:0];
        default: ;
      endcase
    end
  end

  // Command register: taken only while clear, executed then cleared.
  // Formats other than channel control are accepted and cleared only.
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      channel_command_reg_q <= `RST_BYTE;
      state_q <= CMD_IDLE;
    end else begin
      case (state_q)
        CMD_IDLE: begin
          if (channel_command_reg_q != 8'h00) begin
            state_q <= CMD_EXEC;
          end else if (wr_go && idx == `IDX_CMD) begin
            channel_command_reg_q <= wb_req_i.dat[7:0];
          end
        end
        CMD_EXEC: begin
          channel_command_reg_q <= 8'h00;
          state_q <= CMD_IDLE;
        end
        default: state_q <= CMD_IDLE;
      endcase
    end
  end

  // Enable with disable for the same direction leaves it unchanged
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_en_q <= 1'b0;
      rx_en_q <= 1'b0;
    end else if (ctrl_exec) begin
      if (channel_command_reg_q[`CMD_TX_EN] !=
          channel_command_reg_q[`CMD_TX_DIS]) begin
        tx_en_q <= channel_command_reg_q[`CMD_TX_EN];
      end
      if (channel_command_reg_q[`CMD_RX_EN] !=
          channel_command_reg_q[`CMD_RX_DIS]) begin
        rx_en_q <= channel_command_reg_q[`CMD_RX_EN];
      end
    end
  end

  // In-band flow: a stop character arriving with a command still halts
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flow_off_q <= 1'b0;
    end else if (flow_loop_option_q[`FLO_IBE] && rx_char_valid_i &&
                 rx_xoff_match_i) begin
      flow_off_q <= 1'b1;
    end else if (ctrl_exec) begin
      flow_off_q <= 1'b0;
    end else if (rx_char_valid_i && (flow_loop_option_q[`FLO_IXM] ?
                 !rx_xoff_match_i : rx_xon_match_i)) begin
      flow_off_q <= 1'b0;
    end
  end

  // Timeout counts ticks since the last received character
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt_q <= 16'h0000;
      tmo_cnt_q <= 8'h00;
    end else if (rx_char_valid_i) begin
      tick_cnt_q <= 16'h0000;
      tmo_cnt_q <= 8'h00;
    end else if (tick_cnt_q == 16'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 16'h0000;
      if (tmo_cnt_q != 8'hFF) begin
        tmo_cnt_q <= tmo_cnt_q + 8'h01;
      end
    end else begin
      tick_cnt_q <= tick_cnt_q + 16'h0001;
    end
  end

  assign expired = (rx_timeout_period_q != 8'h00) &&
    (tmo_cnt_q >= rx_timeout_period_q);
  assign no_new_data_timeout_en_fire = service_request_enable_q[`SRE_NO_NEW_DATA_TIMEOUT_EN] && armed_q &&
    expired && !rx_fifo_nonempty_i;

  // Armed by a character so one idle spell raises one exception
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      armed_q <= 1'b0;
    end else if (rx_char_valid_i) begin
      armed_q <= 1'b1;
    end else if (no_new_data_timeout_en_fire) begin
      armed_q <= 1'b0;
    end
  end

  // Level requests follow their conditions; sticky ones clear by
  // writing one, and a new event in that cycle wins
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      svc_status_q <= 4'h0;
      no_new_data_timeout_en_flag_q <= 1'b0;
    end else begin
      svc_status_q[`SVS_RX] <= service_request_enable_q[`SRE_RX] &&
        rx_fifo_nonempty_i && (rx_thresh_i || expired);
      // FIFO empty still leaves holding and shift characters queued
      svc_status_q[`SVS_TX] <= tx_en_q &&
        ((service_request_enable_q[`SRE_TXE] && tx_fifo_empty_i) ||
         (service_request_enable_q[`SRE_TXS] && tx_shift_empty_i));
      if (service_request_enable_q[`SRE_MODEM] && modem_change_i) begin
        svc_status_q[`SVS_MDM] <= 1'b1;
      end else if (wr_go && idx == `IDX_SVS &&
                   wb_req_i.dat[`SVS_MDM]) begin
        svc_status_q[`SVS_MDM] <= 1'b0;
      end
      if (no_new_data_timeout_en_fire || par_err) begin
        svc_status_q[`SVS_EXC] <= 1'b1;
      end else if (wr_go && idx == `IDX_SVS &&
                   wb_req_i.dat[`SVS_EXC]) begin
        svc_status_q[`SVS_EXC] <= 1'b0;
      end
      if (no_new_data_timeout_en_fire) begin
        no_new_data_timeout_en_flag_q <= 1'b1;
      end else if (wr_go && idx == `IDX_SVS &&
                   wb_req_i.dat[`SVS_EXC]) begin
        no_new_data_timeout_en_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_n_q <= 1'b1;
    end else begin
      req_n_q <= (svc_status_q == 4'h0);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  a_cmd_clears: assert property (
    (state_q == CMD_IDLE && channel_command_reg_q != 8'h00)
    |=> (state_q == CMD_EXEC) ##1 (channel_command_reg_q == 8'h00))
    else $error("command register not cleared after execution");

  a_ctrl_tx_on: assert property (
    (ctrl_exec && channel_command_reg_q[3:2] == 2'h2) |=> tx_en_q)
    else $error("transmitter enable command not applied");

  a_ctrl_rx_off: assert property (
    (ctrl_exec && channel_command_reg_q[1:0] == 2'h1) |=> !rx_en_q)
    else $error("receiver disable command not applied");

  a_flow_resume: assert property (
    (ctrl_exec && !(rx_char_valid_i && rx_xoff_match_i)) |=> !flow_off_q)
    else $error("command did not clear flow-off flag");

  a_cfg_kept: assert property (
    (state_q == CMD_EXEC && !wr_go) |=> $stable(char_format_option_q) &&
    $stable(flow_loop_option_q) && $stable(service_request_enable_q))
    else $error("command changed configuration");

  a_sre_reserved: assert property (
    (service_request_enable_q & ~`SRE_MASK) == 8'h00)
    else $error("reserved enable bit set");

  a_req_pin: assert property (
    (svc_status_q != 4'h0) |=> !service_request_n_o)
    else $error("request pin not asserted");

  a_tx_gate: assert property (
    (tx_en_q && service_request_enable_q[2:1] == 2'h0)
    |=> !svc_status_q[`SVS_TX])
    else $error("transmit request without enable");

  a_no_new_data_timeout_en_post: assert property (
    no_new_data_timeout_en_fire |=> no_new_data_timeout_en_flag_q && svc_status_q[`SVS_EXC] &&
    (vec == `VEC_RX_EXC))
    else $error("timeout exception not posted");

  a_ixm_resume: assert property (
    (flow_off_q && flow_loop_option_q[`FLO_IXM] && rx_char_valid_i &&
     !rx_xoff_match_i && !ctrl_exec) |=> !flow_off_q)
    else $error("implied resume failed");

  c_both_enable: cover property (
    ctrl_exec && channel_command_reg_q[3:0] == 4'hA);
  c_flow_override: cover property (flow_off_q && ctrl_exec);
  c_no_new_data_timeout_en: cover property (no_new_data_timeout_en_fire);

endmodule // serial_channel_control
`default_nettype wire

// ===== scc_defs.svh
// Register indices, field positions, reset values and timing counts
// for the serial channel control block. Definitions only.
`ifndef SCC_DEFS_SVH
`define SCC_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CMD 6'h05
`define IDX_SRE 6'h06
`define IDX_FMT 6'h08
`define IDX_FLO 6'h09
`define IDX_CCS 6'h0A
`define IDX_SVS 6'h0B
`define IDX_RDS 6'h0C
`define IDX_RTP 6'h0D
`define IDX_VEC 6'h0E

`define RST_BYTE 8'h00

// Channel command fields
`define CMD_TYPE_CTRL 4'h1
`define CMD_TX_EN 3
`define CMD_TX_DIS 2
`define CMD_RX_EN 1
`define CMD_RX_DIS 0

// Service request enable fields
`define SRE_MODEM 7
`define SRE_RX 4
`define SRE_TXE 2
`define SRE_TXS 1
`define SRE_NO_NEW_DATA_TIMEOUT_EN 0
`define SRE_MASK 8'h97

// Character format fields
`define FMT_PAR_ODD 7
`define FMT_IGN_PAR 4
`define PARM_NONE 2'h0
`define PARM_FORCE 2'h1
`define PARM_NORMAL 2'h2

// Flow option fields
`define FLO_IXM 7
`define FLO_IBE 6

// Status fields
`define CCS_TX_EN 0
`define CCS_RX_EN 1
`define CCS_FLOW_OFF 2
`define SVS_RX 0
`define SVS_TX 1
`define SVS_MDM 2
`define SVS_EXC 3
`define RDS_NO_NEW_DATA_TIMEOUT_EN 7

// Vector type codes
`define VEC_NONE 3'h0
`define VEC_MODEM 3'h1
`define VEC_TX 3'h2
`define VEC_RX_DATA 3'h3
`define VEC_RX_EXC 3'h7

// Timeout tick
`define CLK_PERIOD_NS 4
`define TMO_TICK_NS 1000
`define TMO_TICK_CYCLES (`TMO_TICK_NS / `CLK_PERIOD_NS)

`endif

// ===== scc_pkg.sv
// Types shared by the serial channel control block.
// Assumes scc_defs.svh supplies all numeric constants.
package scc_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  typedef struct packed {
    logic par_en;
    logic par_force;
    logic par_odd;
    logic par_check;
    logic [2:0] stop_half;
    logic [3:0] data_bits;
  } frame_cfg_t;

  typedef enum logic [0:0] {CMD_IDLE, CMD_EXEC} cmd_state_t;

endpackage

// ===== scc_char_framer.sv
// Character framing decode and receive parity check.
// Assumes one received character per rx_valid_i pulse.
`timescale 1ns/1ns
`default_nettype none
`include "scc_defs.svh"

module scc_char_framer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Format register
  input wire logic [7:0] fmt_i,
  // Received character
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_char_i,
  input wire logic rx_par_i,
  // Decoded frame and parity result
  output scc_pkg::frame_cfg_t cfg_o,
  output logic rx_par_err_o
);
  import scc_pkg::*;

  function automatic logic par_of(input logic [7:0] c,
                                  input logic [1:0] len);
    logic [7:0] m;
    m = 8'h1F;
    case (len)
      2'h1: m = 8'h3F;
      2'h2: m = 8'h7F;
      2'h3: m = 8'hFF;
      default: m = 8'h1F;
    endcase
    return ^(c & m);
  endfunction

  logic [1:0] parm;
  logic exp_par;
  assign parm = fmt_i[6:5];

  // Force: odd gives one, even gives zero; normal: odd or even sense
  always_comb begin
    if (parm == `PARM_FORCE) begin
      exp_par = fmt_i[`FMT_PAR_ODD];
    end else begin
      exp_par = par_of(rx_char_i, fmt_i[1:0]) ^ fmt_i[`FMT_PAR_ODD];
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_o <= '0;
    end else begin
      cfg_o.par_en <= (parm == `PARM_FORCE) || (parm == `PARM_NORMAL);
      cfg_o.par_force <= (parm == `PARM_FORCE);
      cfg_o.par_odd <= fmt_i[`FMT_PAR_ODD];
      cfg_o.par_check <= !fmt_i[`FMT_IGN_PAR];
      // Unused stop code falls back to one stop bit
      case (fmt_i[3:2])
        2'h1: cfg_o.stop_half <= 3'h3;
        2'h2: cfg_o.stop_half <= 3'h4;
        default: cfg_o.stop_half <= 3'h2;
      endcase
      cfg_o.data_bits <= 4'h5 + {2'h0, fmt_i[1:0]};
    end
  end

  // Unused parity mode 11 checks nothing
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_par_err_o <= 1'b0;
    end else begin
      rx_par_err_o <= rx_valid_i && !fmt_i[`FMT_IGN_PAR] &&
        ((parm == `PARM_FORCE) || (parm == `PARM_NORMAL)) &&
        (rx_par_i != exp_par);
    end
  end

endmodule // scc_char_framer
`default_nettype wire

// ===== scc_line_partner.sv
// Line-side model: remote terminal plus datapath status levels.
// Assumes the bench calls its tasks just after a core clock edge.
`timescale 1ns/1ns
`default_nettype none

module scc_line_partner (
  // Clock
  input wire logic core_clk_i,
  // Datapath levels
  output logic tx_fifo_empty_o = 1'b0,
  output logic tx_shift_empty_o = 1'b0,
  output logic rx_fifo_nonempty_o = 1'b0,
  output logic rx_thresh_o = 1'b0,
  // Line events
  output logic modem_change_o = 1'b0,
  output logic rx_char_valid_o = 1'b0,
  output logic [7:0] rx_char_o = 8'hA5,
  output logic rx_par_o = 1'b0,
  output logic rx_xoff_o = 1'b0,
  output logic rx_xon_o = 1'b0
);
  task automatic set_levels(input logic [3:0] lv);
    {tx_fifo_empty_o, tx_shift_empty_o, rx_fifo_nonempty_o,
     rx_thresh_o} <= lv;
  endtask

  task automatic modem_pulse;
    modem_change_o <= 1'b1;
    @(posedge core_clk_i);
    modem_change_o <= 1'b0;
  endtask

  // Stop/resume matches qualify the character only in its own cycle
  task automatic send_char(input logic [7:0] ch, input logic xoff,
                           input logic xon);
    rx_char_valid_o <= 1'b1;
    rx_char_o <= ch;
    rx_par_o <= ^ch;
    rx_xoff_o <= xoff;
    rx_xon_o <= xon;
    @(posedge core_clk_i);
    rx_char_valid_o <= 1'b0;
    // Stale data is inverted so nothing can latch it by luck
    rx_char_o <= ~ch;
    rx_par_o <= ~^ch;
    rx_xoff_o <= 1'b0;
    rx_xon_o <= 1'b0;
  endtask
endmodule // scc_line_partner

`default_nettype wire

// ===== serial_channel_control_tb_top.sv
// Bench for serial_channel_control: registers, commands, flow,
// format and service requests. Assumes scc_line_partner on the line.
`timescale 1ns/1ns
`default_nettype none
`include "scc_defs.svh"

module serial_channel_control_tb_top;
  import scc_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t req = '0;
  wb_rsp_t rsp;
  frame_cfg_t cfg;
  logic tx_en, rx_en, flow_off, srq_n;
  logic tfe, tse, rne, rth, mdm, rcv, rpar, rxoff, rxon;
  logic [7:0] rch;
  int err_total = 0;
  int samples_checked = 0;

  always #2 core_clk_i = ~core_clk_i;

  serial_channel_control #(.TICK_CYCLES(4)) dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i),
    .wb_req_i(req), .wb_rsp_o(rsp),
    .tx_fifo_empty_i(tfe), .tx_shift_empty_i(tse),
    .rx_fifo_nonempty_i(rne), .rx_thresh_i(rth),
    .modem_change_i(mdm), .rx_char_valid_i(rcv), .rx_char_i(rch),
    .rx_par_bit_i(rpar), .rx_xoff_match_i(rxoff), .rx_xon_match_i(rxon),
    .tx_enable_o(tx_en), .rx_enable_o(rx_en),
    .tx_flow_off_flag_o(flow_off), .service_request_n_o(srq_n),
    .frame_cfg_o(cfg));

  scc_line_partner p (
    .core_clk_i(core_clk_i), .tx_fifo_empty_o(tfe),
    .tx_shift_empty_o(tse), .rx_fifo_nonempty_o(rne),
    .rx_thresh_o(rth), .modem_change_o(mdm), .rx_char_valid_o(rcv),
    .rx_char_o(rch), .rx_par_o(rpar), .rx_xoff_o(rxoff),
    .rx_xon_o(rxon));

  task automatic final_report;
    $display("Checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk_i);
  endtask

  // One classic cycle; the request holds until ack is sampled high
  task automatic wb_cycle(input logic we, input logic [5:0] idx,
                          input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
             sel: 4'hF, dat: {24'h0, wd}};
    do begin
      @(posedge core_clk_i);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    check("bus ack", 32'h1, {31'h0, rsp.ack});
    rd = rsp.dat[7:0];
    req <= '0;
    @(posedge core_clk_i);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] x;
    wb_cycle(1'b1, idx, d, x);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [7:0] e,
                       input string what);
    logic [7:0] d;
    wb_cycle(1'b0, idx, 8'h00, d);
    check(what, {24'h0, e}, {24'h0, d});
  endtask

  // The next command may only go once the register reads zero
  task automatic cmd(input logic [7:0] c);
    logic [7:0] d;
    int n;
    wr(`IDX_CMD, c);
    n = 0;
    do begin
      wb_cycle(1'b0, `IDX_CMD, 8'h00, d);
      n++;
    end while (d !== 8'h00 && n < 20);
    check("command cleared", 32'h0, {24'h0, d});
  endtask

  task automatic t_regs;
    rdchk(`IDX_SRE, 8'h00, "enable reset");
    rdchk(`IDX_FMT, 8'h00, "format reset");
    rdchk(`IDX_FLO, 8'h00, "flow reset");
    wr(`IDX_SRE, 8'hFF);
    rdchk(`IDX_SRE, `SRE_MASK, "enable reserved");
    wr(6'h3F, 8'h5A);
    rdchk(6'h3F, 8'h00, "unmapped");
    wr(`IDX_SRE, 8'h00);
  endtask

  task automatic t_cmd;
    logic [7:0] c [6];
    logic [1:0] e [6];
    c = '{8'h1A, 8'h14, 8'h19, 8'h3A, 8'h1C, 8'h12};
    e = '{2'h3, 2'h1, 2'h2, 2'h2, 2'h2, 2'h3};
    wr(`IDX_FMT, 8'h0B);
    for (int i = 0; i < 6; i++) begin
      cmd(c[i]);
      check("enables", {30'h0, e[i]}, {30'h0, tx_en, rx_en});
      rdchk(`IDX_CCS, {6'h0, e[i][0], e[i][1]}, "chan status");
    end
    rdchk(`IDX_FMT, 8'h0B, "format kept");
  endtask

  task automatic chr(input logic [7:0] c, input logic xf, input logic xn,
                     input logic e, input string what);
    p.send_char(c, xf, xn);
    wait_clk(3);
    check(what, {31'h0, e}, {31'h0, flow_off});
  endtask

  task automatic t_flow;
    wr(`IDX_FLO, 8'h40);
    cmd(8'h44);
    chr(8'h13, 1'b1, 1'b0, 1'b1, "stop char");
    chr(8'h41, 1'b0, 1'b0, 1'b1, "plain char no resume");
    chr(8'h11, 1'b0, 1'b1, 1'b0, "resume char");
    wr(`IDX_FLO, 8'hC0);
    cmd(8'h44);
    chr(8'h13, 1'b1, 1'b0, 1'b1, "stop char");
    chr(8'h41, 1'b0, 1'b0, 1'b0, "implied resume");
    chr(8'h13, 1'b1, 1'b0, 1'b1, "stop char");
    rdchk(`IDX_CCS, 8'h07, "flow status");
    cmd(8'h12);
    check("override", 32'h0, {31'h0, flow_off});
    rdchk(`IDX_CCS, 8'h03, "flow cleared");
    rdchk(`IDX_FLO, 8'hC0, "flow kept");
    wr(`IDX_FLO, 8'h00);
    cmd(8'h44);
  endtask

  function automatic frame_cfg_t fmt_exp(input logic [7:0] f);
    frame_cfg_t e;
    e.par_en = (f[6:5] == 2'h1) || (f[6:5] == 2'h2);
    e.par_force = (f[6:5] == 2'h1);
    e.par_odd = f[7];
    e.par_check = !f[4];
    e.stop_half = (f[3:2] == 2'h1) ? 3'h3 : (f[3:2] == 2'h2) ? 3'h4 : 3'h2;
    e.data_bits = 4'h5 + {2'h0, f[1:0]};
    return e;
  endfunction

  task automatic t_fmt;
    logic [7:0] f [5];
    f = '{8'hC7, 8'h3A, 8'h05, 8'h4C, 8'hD0};
    for (int i = 0; i < 5; i++) begin
      wr(`IDX_FMT, f[i]);
      wait_clk(3);
      check("frame cfg", {21'h0, fmt_exp(f[i])}, {21'h0, cfg});
    end
    wr(`IDX_FMT, 8'h00);
    cmd(8'h42);
  endtask

  task automatic svs(input logic [7:0] e, input logic pin, input string w);
    wait_clk(4);
    rdchk(`IDX_SVS, e, w);
    check("request pin", {31'h0, pin}, {31'h0, srq_n});
  endtask

  task automatic t_srq;
    logic [7:0] d;
    int n;
    wr(`IDX_SVS, 8'h0C);
    wr(`IDX_SRE, 8'h80);
    p.modem_pulse();
    svs(8'h04, 1'b0, "modem request");
    wr(`IDX_SVS, 8'h04);
    svs(8'h00, 1'b1, "modem cleared");
    wr(`IDX_SRE, 8'h00);
    p.modem_pulse();
    svs(8'h00, 1'b1, "modem masked");
    wr(`IDX_SRE, 8'h10);
    p.set_levels(4'h3);
    svs(8'h01, 1'b0, "rx request");
    p.set_levels(4'h0);
    wr(`IDX_SRE, 8'h04);
    svs(8'h00, 1'b1, "tx idle");
    p.set_levels(4'h8);
    svs(8'h02, 1'b0, "tx fifo empty");
    wr(`IDX_SRE, 8'h02);
    svs(8'h00, 1'b1, "tx shift busy");
    p.set_levels(4'hC);
    svs(8'h02, 1'b0, "tx shift empty");
    wr(`IDX_RTP, 8'h02);
    p.send_char(8'h55, 1'b0, 1'b0);
    wr(`IDX_SRE, 8'h01);
    rdchk(`IDX_SVS, 8'h00, "timeout pending");
    n = 0;
    do begin
      wb_cycle(1'b0, `IDX_SVS, 8'h00, d);
      n++;
    end while (d[3] !== 1'b1 && n < 40);
    check("timeout request", 32'h8, {24'h0, d});
    rdchk(`IDX_RDS, 8'h80, "timeout flag");
    rdchk(`IDX_VEC, {5'h0, `VEC_RX_EXC}, "timeout vector");
    wr(`IDX_SVS, 8'h08);
    svs(8'h00, 1'b1, "timeout cleared");
    // Partner sends even parity over eight bits; odd sense must flag it
    wr(`IDX_SRE, 8'h00);
    wr(`IDX_FMT, 8'hC3);
    cmd(8'h42);
    p.send_char(8'h55, 1'b0, 1'b0);
    svs(8'h08, 1'b0, "parity exception");
    wr(`IDX_SVS, 8'h08);
    wr(`IDX_FMT, 8'hD3);
    cmd(8'h42);
    p.send_char(8'h55, 1'b0, 1'b0);
    svs(8'h00, 1'b1, "parity ignored");
  endtask

  initial begin
    #20000;
    err_total++;
    final_report();
  end

  initial begin
    repeat (8) @(posedge core_clk_i);
    rst_i <= 1'b0;
    @(posedge core_clk_i);
    t_regs();
    t_cmd();
    t_flow();
    t_fmt();
    t_srq();
    final_report();
  end
endmodule // serial_channel_control_tb_top

`default_nettype wire
